// file: design/raw_pixel_cfg.svh
// constants for the diagnostic raw pixel framer link
`ifndef RAW_PIXEL_CFG_SVH
`define RAW_PIXEL_CFG_SVH

// ----------------------------------------------------------------
// word layouts
// ----------------------------------------------------------------
`define FRAME_WIDTH      7'd64
`define FIRST_WORD_WIDTH 7'd16
`define SECOND_WORD_WIDTH 7'd32
`define ENERGY_WIDTH     12
`define ID_EVENT         1'b1
`define ID_FRAME         1'b0
`define HEADER_MARK      4'h1
`define TRAILER_MARK     4'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLOCK_MHZ        25
`define PIXEL_TIME_US    20
`define PIXEL_CYCLES     (`PIXEL_TIME_US * `CLOCK_MHZ)
`define LINK_RATE_KBPS   1200
`define BIT_CYCLES_MAX   ((`CLOCK_MHZ * 1000) / `LINK_RATE_KBPS)
`define BIT_DIV          5'd4

`endif

// file: design/raw_pixel_diagnostic_framer.sv
// camera controller end: diagnostic readout framer
`include "raw_pixel_cfg.svh"
`default_nettype none
// Operation
// - read one chip, forward every pixel
// - each pixel slot at most 20 us
// - raw energy sent unchanged, no filtering
// - 64-bit header before, trailer after
// - 16-bit word: id, 12-bit energy, spare
// - second kind: 32-bit word, usual layout
// - second kind operates a single chip
// - host zeroes lower threshold of active columns
// - host shifts active columns across runs
// - link sustains at least 1.2 Mbit/s
// - integration time independent of transmission
// - handler only formats words to packets
// - handler does not accumulate frames
module raw_pixel_diagnostic_framer #(
    parameter int PIXEL_COUNT  = 1024 * 1024,
    parameter int INTEGRATION  = 1250000,
    parameter int CHIP_WIDTH   = 4
) (
    input  wire logic                      clk,
    input  wire logic                      resetn,
    input  wire logic                      start,
    input  wire raw_pixel_pkg::detector_type detectorKind,
    input  wire logic [CHIP_WIDTH-1:0]     chipSelect,
    input  wire logic [31:0]               integrationCycles,
    input  wire logic [`ENERGY_WIDTH-1:0]  pixelEnergy,
    input  wire logic [15:0]               pixelFields,
    output logic                           pixelRequest,
    output logic [CHIP_WIDTH-1:0]          activeChip,
    output logic                           busy,
    output logic                           overrun,
    raw_pixel_link_if.controller           link
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    raw_pixel_pkg::framer_state_type state;
    raw_pixel_pkg::detector_type     kind;
    logic [63:0] shiftWord;
    logic [6:0]  bitsLeft;
    logic [4:0]  divCount;
    logic        bitPhase;
    logic [31:0] integCount;
    logic [31:0] pixelCount;
    logic [15:0] slotCount;
    logic        integrating;
    logic        wordPending;
    logic [31:0] pendingWord;
    logic        serialClock;
    logic        serialData;
    logic        frameActive;

    wire bitTick  = (divCount == `BIT_DIV - 5'd1);
    wire shiftOut = bitTick && bitPhase;
    wire wordDone = shiftOut && (bitsLeft == 7'd1);
    wire idleLine = (bitsLeft == 7'd0);
    wire slotEnd  = (slotCount == 16'(`PIXEL_CYCLES - 1));

    // ----------------------------------------------------------------
    // bit clock divider: 25 MHz / 8 = 3.125 Mbit/s, above the minimum
    // ----------------------------------------------------------------
    // held while no run is pending, so the bit grid starts at a fixed offset
    // from start and the header latency follows the integration count alone
    always_ff @(posedge clk) begin
        if (!resetn || (state == raw_pixel_pkg::IDLE && !integrating)) begin
            divCount <= 5'h00;
            bitPhase <= 1'b0;
        end else if (bitTick) begin
            divCount <= 5'h00;
            bitPhase <= ~bitPhase;
        end else begin
            divCount <= divCount + 5'h01;
        end
    end

    // the chip and kind are latched at start so a run never hops chips
    always_ff @(posedge clk) begin
        if (!resetn) begin
            activeChip <= '0;
            kind       <= raw_pixel_pkg::FIRST_KIND;
        end else if (start && state == raw_pixel_pkg::IDLE && !integrating) begin
            activeChip <= chipSelect;
            kind       <= detectorKind;
        end
    end

    // ----------------------------------------------------------------
    // integration then readout sequence
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state       <= raw_pixel_pkg::IDLE;
            integrating <= 1'b0;
            integCount  <= 32'h0000_0000;
            pixelCount  <= 32'h0000_0000;
        end else begin
            unique case (state)
                raw_pixel_pkg::IDLE: begin
                    // a start during the integration wait is refused
                    if (start && !integrating) begin
                        integrating <= 1'b1;
                        integCount  <= integrationCycles;
                    end else if (integrating) begin
                        if (integCount == 32'h0000_0000) begin
                            integrating <= 1'b0;
                            state       <= raw_pixel_pkg::HEADER;
                        end else begin
                            integCount <= integCount - 32'h0000_0001;
                        end
                    end
                end
                raw_pixel_pkg::HEADER: begin
                    if (wordDone) begin
                        state      <= raw_pixel_pkg::EVENTS;
                        pixelCount <= 32'h0000_0000;
                    end
                end
                raw_pixel_pkg::EVENTS: begin
                    if (slotEnd) begin
                        if (pixelCount == 32'(PIXEL_COUNT - 1)) begin
                            state <= raw_pixel_pkg::TRAILER;
                        end else begin
                            pixelCount <= pixelCount + 32'h0000_0001;
                        end
                    end
                end
                raw_pixel_pkg::TRAILER: begin
                    if (wordDone) begin
                        state <= raw_pixel_pkg::IDLE;
                    end
                end
            endcase
        end
    end

    // fixed pixel slot; the pixel is requested at slot start
    always_ff @(posedge clk) begin
        if (!resetn) begin
            slotCount    <= 16'h0000;
            pixelRequest <= 1'b0;
        end else if (state != raw_pixel_pkg::EVENTS || slotEnd) begin
            slotCount    <= 16'h0000;
            pixelRequest <= 1'b0;
        end else begin
            slotCount    <= slotCount + 16'h0001;
            pixelRequest <= (slotCount == 16'h0000);
        end
    end

    // capture raw sample into a pending word, untouched
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wordPending <= 1'b0;
            pendingWord <= 32'h0000_0000;
            overrun     <= 1'b0;
        end else if (state == raw_pixel_pkg::EVENTS && slotCount == 16'h0002) begin
            wordPending <= 1'b1;
            overrun     <= overrun | wordPending;
            if (kind == raw_pixel_pkg::FIRST_KIND) begin
                // id, energy, three zero spare bits
                pendingWord <= {`ID_EVENT, pixelEnergy, 3'b000, 16'h0000};
            end else begin
                // usual 32-bit event layout, chip id field set to zero
                pendingWord <= {`ID_EVENT, pixelFields[14:0], 4'h0, pixelEnergy};
            end
        end else if (state == raw_pixel_pkg::EVENTS && idleLine && wordPending && bitPhase
                     && bitTick) begin
            wordPending <= 1'b0;
        end else if (state == raw_pixel_pkg::IDLE && start && !integrating) begin
            overrun <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // serialiser, msb first, data changes on falling link clock
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            shiftWord <= 64'h0000_0000_0000_0000;
            bitsLeft  <= 7'd0;
        end else if (shiftOut && !idleLine) begin
            shiftWord <= {shiftWord[62:0], 1'b0};
            bitsLeft  <= bitsLeft - 7'd1;
        end else if (idleLine && bitTick && bitPhase) begin
            if (state == raw_pixel_pkg::HEADER || state == raw_pixel_pkg::TRAILER) begin
                // frame words open with a zero id bit
                shiftWord <= {`ID_FRAME, 3'b000,
                              (state == raw_pixel_pkg::HEADER) ? `HEADER_MARK : `TRAILER_MARK,
                              activeChip, pixelCount,
                              {(24 - CHIP_WIDTH){1'b0}}};
                bitsLeft  <= `FRAME_WIDTH;
            end else if (state == raw_pixel_pkg::EVENTS && wordPending) begin
                shiftWord <= {pendingWord, 32'h0000_0000};
                bitsLeft  <= (kind == raw_pixel_pkg::FIRST_KIND) ? `FIRST_WORD_WIDTH
                                                                  : `SECOND_WORD_WIDTH;
            end
        end
    end

    // link outputs registered
    always_ff @(posedge clk) begin
        if (!resetn) begin
            serialClock <= 1'b0;
            serialData  <= 1'b0;
            frameActive <= 1'b0;
            busy        <= 1'b0;
        end else begin
            serialClock <= bitPhase && !idleLine;
            serialData  <= shiftWord[63];
            frameActive <= !idleLine;
            busy        <= (state != raw_pixel_pkg::IDLE) || integrating || start;
        end
    end

    assign link.serialClock = serialClock;
    assign link.serialData  = serialData;
    assign link.frameActive = frameActive;
endmodule
`default_nettype wire

// file: design/raw_pixel_handler_end.sv
// data handler end: deserialises link words and hands them on
`include "raw_pixel_cfg.svh"
`default_nettype none
module raw_pixel_handler_end (
    input  wire logic                        clk,
    input  wire logic                        resetn,
    input  wire raw_pixel_pkg::detector_type detectorKind,
    raw_pixel_link_if.handler                link,
    output logic [63:0]                      wordData,
    output logic                             wordValid,
    output logic                             wordIsEvent,
    output logic [6:0]                       wordBits
);
    // ----------------------------------------------------------------
    // pin synchronisers, two stages before any logic
    // ----------------------------------------------------------------
    logic [1:0] clockSync;
    logic [1:0] dataSync;
    logic [1:0] activeSync;
    logic       lastClock;
    logic [63:0] shiftIn;
    logic [6:0]  bitCount;
    logic        idBit;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            clockSync  <= 2'b00;
            dataSync   <= 2'b00;
            activeSync <= 2'b00;
            lastClock  <= 1'b0;
        end else begin
            clockSync  <= {clockSync[0], link.serialClock};
            dataSync   <= {dataSync[0], link.serialData};
            activeSync <= {activeSync[0], link.frameActive};
            lastClock  <= clockSync[1];
        end
    end

    wire riseEdge = clockSync[1] && !lastClock;
    // word length follows the id bit, which arrives first
    wire [6:0] wordLength = !idBit ? `FRAME_WIDTH :
                            (detectorKind == raw_pixel_pkg::FIRST_KIND) ? `FIRST_WORD_WIDTH
                                                                       : `SECOND_WORD_WIDTH;
    wire [6:0] idLength = (bitCount == 7'd0) ? 7'd0 : wordLength;

    // ----------------------------------------------------------------
    // shift in; plain word hand-off, no accumulation across frames
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            shiftIn     <= 64'h0000_0000_0000_0000;
            bitCount    <= 7'd0;
            idBit       <= 1'b0;
            wordData    <= 64'h0000_0000_0000_0000;
            wordValid   <= 1'b0;
            wordIsEvent <= 1'b0;
            wordBits    <= 7'd0;
        end else begin
            wordValid <= 1'b0;
            if (!activeSync[1] && !riseEdge) begin
                bitCount <= 7'd0;
            end else if (riseEdge) begin
                shiftIn <= {shiftIn[62:0], dataSync[1]};
                if (bitCount != 7'd0 && bitCount + 7'd1 == idLength) begin
                    // forwarded as received
                    wordData    <= {shiftIn[62:0], dataSync[1]};
                    wordBits    <= idLength;
                    wordIsEvent <= (idLength != `FRAME_WIDTH);
                    wordValid   <= 1'b1;
                    bitCount    <= 7'd0;
                end else if (bitCount == 7'd0) begin
                    // the id bit is kept, later bits would hide it in the shifter
                    shiftIn  <= {63'h0, dataSync[1]};
                    idBit    <= dataSync[1];
                    bitCount <= 7'd1;
                end else begin
                    bitCount <= bitCount + 7'd1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: design/raw_pixel_link_if.sv
// serial data line between camera controller and data handler
`default_nettype none
interface raw_pixel_link_if;
    logic serialClock;
    logic serialData;
    logic frameActive;

    modport controller (output serialClock, output serialData, output frameActive);
    modport handler    (input serialClock, input serialData, input frameActive);
endinterface
`default_nettype wire

// file: design/raw_pixel_pkg.sv
// types shared by both ends of the diagnostic link
`default_nettype none
package raw_pixel_pkg;
    typedef enum logic [0:0] {
        FIRST_KIND  = 1'b0,
        SECOND_KIND = 1'b1
    } detector_type;

    typedef enum logic [3:0] {
        IDLE    = 4'b0001,
        HEADER  = 4'b0010,
        EVENTS  = 4'b0100,
        TRAILER = 4'b1000
    } framer_state_type;
endpackage
`default_nettype wire

// file: test/raw_pixel_link_props.sv
// concurrent checks on the diagnostic link and the framer handshake
`default_nettype none
module raw_pixel_link_props (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic busy,
    input wire logic pixelRequest,
    input wire logic serialClock,
    input wire logic serialData,
    input wire logic frameActive
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // ----------------------------------------------------------------
    // pixel slot spacing
    // ----------------------------------------------------------------
    // saturating gap counter, so an idle stretch cannot wrap to a small value
    logic [9:0] gap;
    logic       armed;
    always_ff @(posedge clk) begin
        if (!resetn || !busy) begin
            gap   <= 10'h000;
            armed <= 1'b0;
        end else if (pixelRequest) begin
            gap   <= 10'h001;
            armed <= 1'b1;
        end else if (gap != 10'h3ff) begin
            gap <= gap + 10'h001;
        end
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    a_slot_within_limit:
    assert property (pixelRequest && armed |-> gap <= 10'h1f4)
        else $error("pixel slot longer than allowed");
    a_request_one_pulse:
    assert property (pixelRequest |=> !pixelRequest)
        else $error("pixel request wider than one cycle");
    a_request_in_run:
    assert property (pixelRequest |-> busy)
        else $error("pixel request outside a run");
    a_start_sets_busy:
    assert property (start && !busy |=> busy)
        else $error("accepted start did not raise busy");
    a_integration_quiet:
    assert property (start && !busy |=> !frameActive [*8])
        else $error("link word during integration wait");
    a_link_rate_floor:
    assert property ($rose(serialClock) && frameActive |->
        ##[1:20] ($rose(serialClock) || !frameActive))
        else $error("link bit period too long");
    a_bit_high_time:
    assert property ($rose(serialClock) |-> serialClock [*4] ##1 !serialClock)
        else $error("link clock high phase wrong");
    a_data_held_high:
    assert property (serialClock && $past(serialClock) |-> $stable(serialData))
        else $error("data moved while link clock high");
    a_idle_line_quiet:
    assert property (!busy |-> !frameActive)
        else $error("word shifting while idle");

    c_run_started: cover property (start && !busy);
    c_slot_pair: cover property (pixelRequest && armed);
    c_word_done: cover property ($fell(frameActive));
endmodule
`default_nettype wire

// file: test/tb.sv
// self-checking bench joining framer and handler across the link
`include "raw_pixel_cfg.svh"
`default_nettype none
`define CHECK(got, exp) begin nCompared++; if ((got) !== (exp)) begin errTotal++; $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NPIX = 4;
    localparam logic [11:0] ENERGY [4] = '{12'hfff, 12'h001, 12'ha5a, 12'h000};
    typedef struct { logic [63:0] data; logic isEvent; logic [6:0] bits; } word_type;

    logic                        clk;
    logic                        resetn;
    logic                        start;
    raw_pixel_pkg::detector_type detectorKind;
    logic [3:0]                  chipSelect;
    logic [31:0]                 integrationCycles;
    logic [11:0]                 pixelEnergy;
    logic [15:0]                 pixelFields;
    logic                        pixelRequest;
    logic [3:0]                  activeChip;
    logic                        busy;
    logic                        overrun;
    logic [63:0]                 wordData;
    logic                        wordValid;
    logic                        wordIsEvent;
    logic [6:0]                  wordBits;
    word_type                    got [$];
    int                          errTotal;
    int                          nCompared;
    int                          pixIdx;
    int                          latA;
    int                          latB;

    raw_pixel_link_if link();
    raw_pixel_diagnostic_framer #(.PIXEL_COUNT(NPIX)) i_raw_pixel_diagnostic_framer (
        .clk(clk), .resetn(resetn), .start(start), .detectorKind(detectorKind),
        .chipSelect(chipSelect), .integrationCycles(integrationCycles),
        .pixelEnergy(pixelEnergy), .pixelFields(pixelFields), .pixelRequest(pixelRequest),
        .activeChip(activeChip), .busy(busy), .overrun(overrun), .link(link));
    raw_pixel_handler_end i_raw_pixel_handler_end (
        .clk(clk), .resetn(resetn), .detectorKind(detectorKind), .link(link),
        .wordData(wordData), .wordValid(wordValid), .wordIsEvent(wordIsEvent),
        .wordBits(wordBits));
    raw_pixel_link_props i_raw_pixel_link_props (
        .clk(clk), .resetn(resetn), .start(start), .busy(busy),
        .pixelRequest(pixelRequest), .serialClock(link.serialClock),
        .serialData(link.serialData), .frameActive(link.frameActive));

    // ----------------------------------------------------------------
    // clock, word capture and pixel source
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // a word pulse stands one cycle, so it is taken at the falling edge inside it
    always @(negedge clk) begin
        if (wordValid === 1'b1) begin
            got.push_back(word_type'{wordData, wordIsEvent, wordBits});
        end
    end

    // the next energy is set well after capture at slot cycle 2 of this pixel
    initial forever begin
        @(negedge clk);
        if (pixelRequest === 1'b1) begin
            repeat (10) @(negedge clk);
            pixIdx++;
            pixelEnergy = ENERGY[pixIdx % 4];
            pixelFields = ~pixelFields;
        end
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic testDone;
        $display("compared %0d, mismatches %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one run; a second start while busy must be ignored, so one frame only
    task automatic runFrame(input raw_pixel_pkg::detector_type kind, input logic [3:0] chip,
                            input logic [31:0] integ, output int lat);
        int n;
        got.delete();
        pixIdx = 0;
        @(negedge clk);
        detectorKind      = kind;
        chipSelect        = chip;
        integrationCycles = integ;
        pixelEnergy       = ENERGY[0];
        start             = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (3) @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        lat = 0;
        while (link.frameActive !== 1'b1 && lat < 2000) begin
            @(negedge clk);
            lat++;
        end
        n = 0;
        while (busy !== 1'b0 && n < 8000) begin
            @(negedge clk);
            n++;
        end
        repeat (20) @(negedge clk);
        `CHECK(busy, 1'b0)
        `CHECK(activeChip, chip)
        `CHECK(overrun, 1'b0)
        `CHECK(got.size(), NPIX + 2)
        if (got.size() != NPIX + 2) return;
        `CHECK({got[0].isEvent, got[0].bits}, {1'b0, `FRAME_WIDTH})
        `CHECK(got[0].data[63:52], {4'h0, `HEADER_MARK, chip})
        `CHECK({got[NPIX+1].isEvent, got[NPIX+1].bits}, {1'b0, `FRAME_WIDTH})
        `CHECK(got[NPIX+1].data[63:52], {4'h0, `TRAILER_MARK, chip})
        for (int k = 0; k < NPIX; k++) begin
            `CHECK(got[k+1].isEvent, 1'b1)
            if (kind == raw_pixel_pkg::FIRST_KIND) begin
                `CHECK(got[k+1].bits, `FIRST_WORD_WIDTH)
                `CHECK(got[k+1].data[15:0], {1'b1, ENERGY[k], 3'b000})
            end else begin
                `CHECK(got[k+1].bits, `SECOND_WORD_WIDTH)
                `CHECK(got[k+1].data[31], 1'b1)
                `CHECK(got[k+1].data[11:0], ENERGY[k])
                `CHECK(got[k+1].data[30:12], {(k % 2) ? 15'h25a5 : 15'h5a5a, 4'h0})
            end
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        resetn            = 1'b0;
        start             = 1'b0;
        detectorKind      = raw_pixel_pkg::FIRST_KIND;
        chipSelect        = 4'h0;
        integrationCycles = 32'h0000_0014;
        pixelEnergy       = 12'h000;
        pixelFields       = 16'h5a5a;
        errTotal          = 0;
        nCompared         = 0;
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        runFrame(raw_pixel_pkg::FIRST_KIND, 4'h0, 32'h0000_0014, latA);
        runFrame(raw_pixel_pkg::FIRST_KIND, 4'hf, 32'h0000_003c, latB);
        `CHECK(latB - latA, 40)
        runFrame(raw_pixel_pkg::SECOND_KIND, 4'h5, 32'h0000_0014, latA);
        testDone();
    end

    // three runs take about 10000 cycles; three times that means a hang
    initial begin
        repeat (30000) @(posedge clk);
        errTotal++;
        testDone();
    end
endmodule
`default_nettype wire
